// >>> include/bcch_pkg.sv
package bcch_pkg;

  // Command codes carried on the command port.
  typedef enum logic [2:0] {
    BCCH_CMD_SOFT_RESET  = 3'h0,
    BCCH_CMD_FAULT_READ  = 3'h1,
    BCCH_CMD_FW_VERSION  = 3'h2,
    BCCH_CMD_FAST_SLOT   = 3'h3,
    BCCH_CMD_SELECT_50HZ = 3'h4
  } bcch_cmd_code_t;

  localparam int unsigned BCCH_DATA_W = 16;
  localparam int unsigned BCCH_CYC_W  = 22;
  localparam int unsigned BCCH_CHAN_W = 5;

  localparam int unsigned BCCH_CLK_PERIOD_NS = 10;
  localparam int unsigned BCCH_NS_PER_MS     = 1000000;
  localparam int unsigned BCCH_NS_PER_US     = 1000;

  // Slot times in milliseconds and integration periods in microseconds.
  localparam int unsigned BCCH_SLOT_DEF_MS  = 22;
  localparam int unsigned BCCH_SLOT_FAST_MS = 9;
  localparam int unsigned BCCH_INTEG_60_US  = 16700;
  localparam int unsigned BCCH_INTEG_50_US  = 20000;

  localparam int unsigned BCCH_SLOT_DEF_CYC =
    BCCH_SLOT_DEF_MS * BCCH_NS_PER_MS / BCCH_CLK_PERIOD_NS;
  localparam int unsigned BCCH_SLOT_FAST_CYC =
    BCCH_SLOT_FAST_MS * BCCH_NS_PER_MS / BCCH_CLK_PERIOD_NS;
  localparam int unsigned BCCH_INTEG_60_CYC =
    BCCH_INTEG_60_US * BCCH_NS_PER_US / BCCH_CLK_PERIOD_NS;
  localparam int unsigned BCCH_INTEG_50_CYC =
    BCCH_INTEG_50_US * BCCH_NS_PER_US / BCCH_CLK_PERIOD_NS;

  localparam int unsigned BCCH_NUM_CHAN_DEF = 8;
  localparam int unsigned BCCH_FAULT_W_DEF  = 8;
  localparam logic [15:0] BCCH_FW_VERSION_X100_DEF = 16'h0064;

  localparam logic        BCCH_MODE_RST  = 1'b0;
  localparam logic [15:0] BCCH_DATA_RST  = 16'h0000;

  typedef struct packed {
    logic           valid;
    bcch_cmd_code_t code;
  } bcch_cmd_t;

  typedef struct packed {
    logic                   valid;
    logic [BCCH_DATA_W-1:0] data;
  } bcch_rsp_t;

endpackage

// >>> src/bcch_core.sv
// Operation
// - Client issues commands; some return response data.
// - Soft reset equals hard reset, board-local only; here it clears only the fast and 50 Hz mode bits and pulses board_reset_o.
// - Fast command in 60 Hz: slot 22 to 9 ms.
// - Repeated fast command ignored, slot unchanged.
// - Fast mode persists until a board reset.
// - 50 Hz command: integration 16.7 to 20.0 ms; ignored in fast mode.
// - Only reset returns to default 60 Hz mode.
// - Repeated 50 Hz command is ignored.
// - Version query returns version times 100.
// - Channel indices start at zero, variant bound.
// - Hardware fault status register, quickly readable.
`timescale 1ns/1ps
`default_nettype none

module bcch_core
  import bcch_pkg::*;
#(
  parameter int unsigned NUM_CHAN        = BCCH_NUM_CHAN_DEF,
  parameter int unsigned FAULT_W         = BCCH_FAULT_W_DEF,
  parameter logic [15:0] FW_VERSION_X100 = BCCH_FW_VERSION_X100_DEF,
  parameter int unsigned SLOT_DEF_CYC    = BCCH_SLOT_DEF_CYC,
  parameter int unsigned SLOT_FAST_CYC   = BCCH_SLOT_FAST_CYC,
  parameter int unsigned INTEG_60_CYC    = BCCH_INTEG_60_CYC,
  parameter int unsigned INTEG_50_CYC    = BCCH_INTEG_50_CYC
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_b_i,
  input  wire bcch_cmd_t              cmd_i,
  input  wire logic [BCCH_CHAN_W-1:0] chan_i,
  input  wire logic [FAULT_W-1:0]     fault_pins_i,
  output bcch_rsp_t                   rsp_o,
  output logic                        cmd_done_o,
  output logic                        cmd_err_o,
  output logic                        board_reset_o,
  output logic                        chan_ok_o,
  output logic                        fast_mode_o,
  output logic                        rej50_mode_o,
  output logic [BCCH_CYC_W-1:0]       slot_cycles_o,
  output logic [BCCH_CYC_W-1:0]       integ_cycles_o
);

  localparam logic [BCCH_CYC_W-1:0] SLOT_DEF  = BCCH_CYC_W'(SLOT_DEF_CYC);
  localparam logic [BCCH_CYC_W-1:0] SLOT_FAST = BCCH_CYC_W'(SLOT_FAST_CYC);
  localparam logic [BCCH_CYC_W-1:0] INTEG_60  = BCCH_CYC_W'(INTEG_60_CYC);
  localparam logic [BCCH_CYC_W-1:0] INTEG_50  = BCCH_CYC_W'(INTEG_50_CYC);

  function automatic logic is_cmd(input bcch_cmd_t c,
                                  input bcch_cmd_code_t k);
    is_cmd = c.valid && (c.code == k);
  endfunction

  function automatic logic chan_in_range(
    input logic [BCCH_CHAN_W-1:0] ch);
    chan_in_range = (32'(ch) < NUM_CHAN);
  endfunction

  logic [FAULT_W-1:0]     fault_sync;
  logic [FAULT_W-1:0]     status_r;
  logic [FAULT_W-1:0]     status_nxt;
  logic                   fast_r;
  logic                   fast_nxt;
  logic                   rej50_r;
  logic                   rej50_nxt;
  bcch_rsp_t              rsp_r;
  bcch_rsp_t              rsp_nxt;
  logic                   done_r;
  logic                   done_nxt;
  logic                   err_r;
  logic                   err_nxt;
  logic                   brst_r;
  logic                   brst_nxt;
  logic                   chan_ok_r;
  logic                   chan_ok_nxt;
  logic [BCCH_CYC_W-1:0]  slot_r;
  logic [BCCH_CYC_W-1:0]  slot_nxt;
  logic [BCCH_CYC_W-1:0]  integ_r;
  logic [BCCH_CYC_W-1:0]  integ_nxt;

  bcch_sync #(
    .W (FAULT_W)
  ) u_fault_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .async_i    (fault_pins_i),
    .sync_o     (fault_sync)
  );

  always_comb begin
    status_nxt  = fault_sync;
    chan_ok_nxt = chan_in_range(chan_i);
    fast_nxt    = fast_r;
    rej50_nxt   = rej50_r;
    rsp_nxt     = '0;
    done_nxt    = 1'b0;
    err_nxt     = 1'b0;
    brst_nxt    = 1'b0;
    if (cmd_i.valid) begin
      unique case (cmd_i.code)
        BCCH_CMD_SOFT_RESET: begin
          // Only this block's own state returns to defaults.
          fast_nxt  = BCCH_MODE_RST;
          rej50_nxt = BCCH_MODE_RST;
          brst_nxt  = 1'b1;
          done_nxt  = 1'b1;
        end
        BCCH_CMD_FAULT_READ: begin
          rsp_nxt.valid = 1'b1;
          rsp_nxt.data  = BCCH_DATA_W'(status_r);
          done_nxt      = 1'b1;
        end
        BCCH_CMD_FW_VERSION: begin
          rsp_nxt.valid = 1'b1;
          rsp_nxt.data  = FW_VERSION_X100;
          done_nxt      = 1'b1;
        end
        BCCH_CMD_FAST_SLOT: begin
          // Fast mode is only reachable from the 60 Hz mode.
          if (!rej50_r) begin
            fast_nxt = 1'b1;
          end
          done_nxt = 1'b1;
        end
        BCCH_CMD_SELECT_50HZ: begin
          // The 9 ms slot cannot hold a 20 ms integration.
          if (!fast_r) begin
            rej50_nxt = 1'b1;
          end
          done_nxt = 1'b1;
        end
        default: begin
          err_nxt = 1'b1;
        end
      endcase
    end
    slot_nxt  = fast_nxt ? SLOT_FAST : SLOT_DEF;
    integ_nxt = rej50_nxt ? INTEG_50 : INTEG_60;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_r  <= '0;
      fast_r    <= BCCH_MODE_RST;
      rej50_r   <= BCCH_MODE_RST;
      rsp_r     <= '0;
      done_r    <= 1'b0;
      err_r     <= 1'b0;
      brst_r    <= 1'b0;
      chan_ok_r <= 1'b0;
      slot_r    <= SLOT_DEF;
      integ_r   <= INTEG_60;
    end else begin
      status_r  <= status_nxt;
      fast_r    <= fast_nxt;
      rej50_r   <= rej50_nxt;
      rsp_r     <= rsp_nxt;
      done_r    <= done_nxt;
      err_r     <= err_nxt;
      brst_r    <= brst_nxt;
      chan_ok_r <= chan_ok_nxt;
      slot_r    <= slot_nxt;
      integ_r   <= integ_nxt;
    end
  end

  assign rsp_o          = rsp_r;
  assign cmd_done_o     = done_r;
  assign cmd_err_o      = err_r;
  assign board_reset_o  = brst_r;
  assign chan_ok_o      = chan_ok_r;
  assign fast_mode_o    = fast_r;
  assign rej50_mode_o   = rej50_r;
  assign slot_cycles_o  = slot_r;
  assign integ_cycles_o = integ_r;

  a_soft_reset_defaults: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    is_cmd(cmd_i, BCCH_CMD_SOFT_RESET) |=>
      !fast_mode_o && !rej50_mode_o && board_reset_o &&
      slot_cycles_o == SLOT_DEF && integ_cycles_o == INTEG_60)
    else $error("soft reset did not restore the default state");

  a_fast_enters: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    is_cmd(cmd_i, BCCH_CMD_FAST_SLOT) && !rej50_r && !fast_r |=>
      fast_mode_o && slot_cycles_o == SLOT_FAST)
    else $error("fast command did not shorten the slot time");

  a_fast_repeat_ignored: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    is_cmd(cmd_i, BCCH_CMD_FAST_SLOT) && fast_r |=>
      $stable(slot_cycles_o) && fast_mode_o)
    else $error("repeated fast command changed the slot time");

  a_fast_sticky: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    fast_r && !is_cmd(cmd_i, BCCH_CMD_SOFT_RESET) |=>
      fast_mode_o && slot_cycles_o == SLOT_FAST)
    else $error("fast mode left without a reset");

  a_rej50_enters: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    is_cmd(cmd_i, BCCH_CMD_SELECT_50HZ) && !fast_r |=>
      rej50_mode_o && integ_cycles_o == INTEG_50)
    else $error("50 Hz command did not lengthen integration");

  a_rej50_sticky: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    rej50_r && !is_cmd(cmd_i, BCCH_CMD_SOFT_RESET) |=>
      rej50_mode_o && integ_cycles_o == INTEG_50)
    else $error("50 Hz mode left without a reset");

  a_rej50_repeat_ignored: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    is_cmd(cmd_i, BCCH_CMD_SELECT_50HZ) && rej50_r |=>
      $stable(integ_cycles_o) && $stable(slot_cycles_o))
    else $error("repeated 50 Hz command changed the timing");

  a_version_answer: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    is_cmd(cmd_i, BCCH_CMD_FW_VERSION) |=>
      rsp_o.valid && rsp_o.data == FW_VERSION_X100 ##1
      (rsp_o.valid == (is_cmd($past(cmd_i), BCCH_CMD_FW_VERSION) ||
                       is_cmd($past(cmd_i), BCCH_CMD_FAULT_READ))))
    else $error("version answer wrong or not a single pulse");

  a_chan_range_check: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    rst_b_i && $past(rst_b_i) |->
      chan_ok_o == (32'($past(chan_i)) < NUM_CHAN))
    else $error("channel range flag disagrees with the index");

  a_fault_read_data: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    is_cmd(cmd_i, BCCH_CMD_FAULT_READ) |=>
      rsp_o.valid && rsp_o.data == BCCH_DATA_W'($past(status_r)))
    else $error("fault read returned the wrong status");

  a_modes_exclusive: assert property (
    @(posedge core_clk_i) disable iff (!rst_b_i)
    !(fast_mode_o && rej50_mode_o))
    else $error("fast and 50 Hz modes both set");

endmodule

`default_nettype wire

// >>> src/bcch_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for a bus of independent level signals.
module bcch_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

`default_nettype wire

// >>> test/bcch_client.sv
`timescale 1ns/1ps
`default_nettype none

// Command client: turns a request into a one-cycle command strobe.
module bcch_client
  import bcch_pkg::*;
(
  input  wire logic           core_clk_i,
  input  wire logic           go_i,
  input  wire bcch_cmd_code_t code_i,
  output bcch_cmd_t           cmd_o
);
  initial cmd_o = '0;

  // Idle cycles invert the previous code, so the stale code returns every second idle cycle; valid stays low.
  always @(posedge core_clk_i) begin
    cmd_o.valid <= go_i;
    cmd_o.code  <= go_i ? code_i : bcch_cmd_code_t'(~cmd_o.code);
  end
endmodule

`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
  import bcch_pkg::*;
;
  localparam int unsigned CPM = BCCH_NS_PER_MS / BCCH_CLK_PERIOD_NS;
  localparam int unsigned CPU = BCCH_NS_PER_US / BCCH_CLK_PERIOD_NS;
  localparam logic [15:0] FW_X100 = 16'h0135;

  logic                   core_clk_i;
  logic                   rst_b_i;
  logic                   go;
  bcch_cmd_code_t         code;
  bcch_cmd_t              cmd;
  logic [BCCH_CHAN_W-1:0] chan;
  logic [7:0]             fault;
  bcch_rsp_t              rsp;
  logic                   done;
  logic                   err;
  logic                   brst;
  logic                   chan_ok;
  logic                   fast;
  logic                   rej50;
  logic [BCCH_CYC_W-1:0]  slot;
  logic [BCCH_CYC_W-1:0]  integ;
  int                     n_errors;
  int                     n_compared;

  bcch_client u_bcch_client (
    .core_clk_i (core_clk_i),
    .go_i       (go),
    .code_i     (code),
    .cmd_o      (cmd)
  );

  bcch_core #(
    .FW_VERSION_X100 (FW_X100)
  ) u_bcch_core (
    .core_clk_i     (core_clk_i),
    .rst_b_i        (rst_b_i),
    .cmd_i          (cmd),
    .chan_i         (chan),
    .fault_pins_i   (fault),
    .rsp_o          (rsp),
    .cmd_done_o     (done),
    .cmd_err_o      (err),
    .board_reset_o  (brst),
    .chan_ok_o      (chan_ok),
    .fast_mode_o    (fast),
    .rej50_mode_o   (rej50),
    .slot_cycles_o  (slot),
    .integ_cycles_o (integ)
  );

  always #5 core_clk_i = ~core_clk_i;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Returns just after the edge at which the answer appears.
  task automatic issue(input bcch_cmd_code_t c);
    @(posedge core_clk_i);
    go   <= 1'b1;
    code <= c;
    @(posedge core_clk_i);
    go   <= 1'b0;
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic pulses(input logic rv, input logic d, input logic e,
                        input logic b);
    chk({rsp.valid, done, err, brst}, {rv, d, e, b});
  endtask

  task automatic modes(input logic f, input logic r);
    chk({fast, rej50}, {f, r});
    chk(slot, (f ? BCCH_SLOT_FAST_MS : BCCH_SLOT_DEF_MS) * CPM);
    chk(integ, (r ? BCCH_INTEG_50_US : BCCH_INTEG_60_US) * CPU);
  endtask

  task automatic t_version();
    issue(BCCH_CMD_FW_VERSION);
    pulses(1'b1, 1'b1, 1'b0, 1'b0);
    chk(rsp.data, FW_X100);
  endtask

  task automatic t_fast();
    issue(BCCH_CMD_FAST_SLOT);
    modes(1'b1, 1'b0);
    issue(BCCH_CMD_FAST_SLOT);
    modes(1'b1, 1'b0);
    issue(BCCH_CMD_SELECT_50HZ);
    modes(1'b1, 1'b0);
    issue(bcch_cmd_code_t'(3'h5));
    pulses(1'b0, 1'b0, 1'b1, 1'b0);
    modes(1'b1, 1'b0);
  endtask

  task automatic t_soft();
    issue(BCCH_CMD_SOFT_RESET);
    pulses(1'b0, 1'b1, 1'b0, 1'b1);
    modes(1'b0, 1'b0);
  endtask

  task automatic t_rej50();
    issue(BCCH_CMD_SELECT_50HZ);
    modes(1'b0, 1'b1);
    issue(BCCH_CMD_SELECT_50HZ);
    modes(1'b0, 1'b1);
    issue(BCCH_CMD_FAST_SLOT);
    modes(1'b0, 1'b1);
  endtask

  task automatic t_fault();
    @(posedge core_clk_i);
    fault <= 8'ha5;
    repeat (3) @(posedge core_clk_i);
    issue(BCCH_CMD_FAULT_READ);
    pulses(1'b1, 1'b1, 1'b0, 1'b0);
    chk(rsp.data, 16'h00a5);
  endtask

  // A hard reset in mid-run must also leave fast mode.
  task automatic t_hard();
    issue(BCCH_CMD_FAST_SLOT);
    pulses(1'b0, 1'b1, 1'b0, 1'b0);
    modes(1'b1, 1'b0);
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    #1;
    pulses(1'b0, 1'b0, 1'b0, 1'b0);
    modes(1'b0, 1'b0);
  endtask

  task automatic t_chan();
    logic [BCCH_CHAN_W-1:0] v[4];
    v = '{5'h00, 5'h07, 5'h08, 5'h1f};
    foreach (v[i]) begin
      @(posedge core_clk_i);
      chan <= v[i];
      @(posedge core_clk_i);
      #1;
      chk(chan_ok, v[i] < 5'h08);
    end
  endtask

  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end

  initial begin
    core_clk_i = 1'b0;
    rst_b_i    = 1'b0;
    go         = 1'b0;
    code       = BCCH_CMD_SOFT_RESET;
    chan       = '0;
    fault      = 8'h00;
    n_errors   = 0;
    n_compared = 0;
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    #1;
    modes(1'b0, 1'b0);
    t_version();
    t_fast();
    t_soft();
    t_rej50();
    t_soft();
    t_fault();
    t_chan();
    t_hard();
    end_of_test();
  end
endmodule

`default_nettype wire
